// >>> shared/sense_pkg.sv
// Constants and carrier types for the sense data reporter
package sense_pkg;
  localparam logic [7:0] OPC_SENSE = 8'h03;
  localparam int LUN_MSB = 7;
  localparam int LUN_LSB = 5;
  localparam int FLAG_BIT = 1;
  localparam int LINK_BIT = 0;
  localparam logic [7:0] STD_LEN = 8'h04;
  localparam logic [7:0] EXT_MAX_LEN = 8'h08;
  localparam logic [2:0] EXT_CLASS = 3'h7;
  localparam logic [3:0] EXT_FORMAT = 4'h0;
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_LINKED_GOOD = 8'h10;
  localparam logic [2:0] CLS_DRIVE = 3'h0;
  localparam logic [2:0] CLS_TARGET = 3'h1;
  localparam logic [2:0] CLS_SYSTEM = 3'h2;
  localparam logic [2:0] CLS_VENDOR = 3'h3;
  localparam logic [3:0] CD_NO_SENSE = 4'h0;
  localparam logic [3:0] CD_NO_INDEX = 4'h1;
  localparam logic [3:0] CD_NO_SEEK_DONE = 4'h2;
  localparam logic [3:0] CD_WRITE_FAULT = 4'h3;
  localparam logic [3:0] CD_NOT_READY = 4'h4;
  localparam logic [3:0] CD_NOT_SELECTED = 4'h5;
  localparam logic [3:0] CD_NO_TRACK0 = 4'h6;
  localparam logic [3:0] CD_MULTI_SEL = 4'h7;
  localparam logic [3:0] CD_NO_MEDIA = 4'h9;
  localparam logic [3:0] CD_ID_READ = 4'h0;
  localparam logic [3:0] CD_UNCORRECTABLE = 4'h1;
  localparam logic [3:0] CD_ID_MARK = 4'h2;
  localparam logic [3:0] CD_DATA_MARK = 4'h3;
  localparam logic [3:0] CD_BLOCK_MISSING = 4'h4;
  localparam logic [3:0] CD_SEEK = 4'h5;
  localparam logic [3:0] CD_DMA_TIMEOUT = 4'h6;
  localparam logic [3:0] CD_WRITE_PROT = 4'h7;
  localparam int RETRY_LIMIT = 16;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] alloc;
    logic [7:0] rsv3;
    logic [7:0] rsv2;
    logic [7:0] lun_byte;
    logic [7:0] opcode;
  } cdb_t;

  typedef struct packed {
    logic addr_valid;
    logic [2:0] error_class;
    logic [3:0] error_code;
    logic [3:0] sense_key;
    logic [31:0] lba;
  } sense_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DISC = 2'b01,
    S_DATA = 2'b10,
    S_STAT = 2'b11
  } state_t;
endpackage

// >>> hw/sense_store.sv
// Held sense information, kept until an access command clears it
`timescale 1ns/1ps
`default_nettype none
module sense_store (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire sense_pkg::sense_t i_sense,
  input wire logic i_clear,
  output sense_pkg::sense_t o_sense
);
  import sense_pkg::*;
  sense_t held;
  sense_t next_held;

  // cleared only by access commands; a new error wins over the clear
  always_comb begin
    next_held = held;
    if (i_set) begin
      next_held = i_sense;
    end else if (i_clear) begin
      next_held = '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  assign o_sense = held;
endmodule
`default_nettype wire

// >>> hw/sense_reporter.sv
// Sense request command interpreter: decodes the command block and returns sense data
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Operation code 03 in byte 0 marks a sense request.
// - Byte 1 top three bits give the unit; low bits are zero.
// - Byte 4 is the allocated count and picks the format.
// - Count four or less sends exactly four standard-format bytes.
// - Larger count sends extended data, capped by request and maximum length.
// - Flag matters only with link; both set raise an interrupt request.
// - Link set chains to next command after success; status always returned.
// - Disconnect only when unit busy elsewhere and disconnect is supported.
// - Held sense survives until an access command clears it.
// - Standard byte 0 bit 7 set only when address is valid.
// - Standard byte 0 bits 6..4 hold error class 0 to 3.
// - Standard byte 0 bits 3..0 hold the error code.
// - Standard byte 1 top bits zero; 21-bit address follows, high first.
// - Drive class codes from no error through media not loaded.
// - Target class codes for identifier, mark, seek and uncorrectable faults.
// - Code 14 reports a bad block sequence or missing block.
// - Code 16 reports a suspended DMA service needing retries.
// - Write protection aborts the outstanding write and reports code 17.
// - Extended byte 0 bit 7 validates bytes 3..6; byte 2 holds key.
module sense_reporter (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_cmd_valid,
  input wire sense_pkg::cdb_t i_cmd,
  input wire logic i_lun_busy_other,
  input wire logic i_disc_supported,
  input wire logic i_access_cmd,
  input wire logic i_err_valid,
  input wire sense_pkg::sense_t i_err,
  input wire logic i_write_active,
  input wire logic i_din_ack,
  output logic o_busy,
  output logic o_disconnect,
  output logic o_din_valid,
  output logic [7:0] o_din_byte,
  output logic o_status_valid,
  output logic [7:0] o_status,
  output logic o_link_next,
  output logic o_intr_req,
  output logic [2:0] o_lun,
  output logic o_abort_write
);
  import sense_pkg::*;

  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  sense_t held;
  logic wp_hit;
  // write protection during a write aborts it
  assign wp_hit = i_err_valid && i_err.error_class == CLS_TARGET
                  && i_err.error_code == CD_WRITE_PROT;

  sense_store u_store (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_set(i_err_valid),
    .i_sense(i_err),
    .i_clear(i_access_cmd),
    .o_sense(held)
  );

  state_t state;
  state_t next_state;
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] idx;
  logic [7:0] next_idx;
  logic ext;
  logic next_ext;
  logic link;
  logic next_link;
  logic flag;
  logic next_flag;
  logic good;
  logic next_good;
  logic [2:0] lun;
  logic [2:0] next_lun;
  logic busy;
  logic next_busy;
  logic disc;
  logic next_disc;
  logic din_valid;
  logic next_din_valid;
  logic [7:0] din_byte;
  logic [7:0] next_din_byte;
  logic stat_valid;
  logic next_stat_valid;
  logic [7:0] stat;
  logic [7:0] next_stat;
  logic link_next;
  logic next_link_next;
  logic intr;
  logic next_intr;
  logic abort_wr;
  logic next_abort_wr;
  logic cmd_ok;
  logic [7:0] req_len;
  logic [7:0] sel_byte;
  logic [7:0] sel_idx;
  logic sel_ext;

  always_comb begin
    cmd_ok = 1'b0;
    if (i_cmd.opcode == OPC_SENSE) begin
      cmd_ok = 1'b1;
    end
    // low bits of unit byte must be zero
    if (i_cmd.lun_byte[LUN_LSB-1:0] != 5'h00) begin
      cmd_ok = 1'b0;
    end
    if (i_cmd.rsv2 != 8'h00 || i_cmd.rsv3 != 8'h00) begin
      cmd_ok = 1'b0;
    end
    // four or fewer gives four standard bytes
    // extended length limited by request and maximum
    if (i_cmd.alloc <= STD_LEN) begin
      req_len = STD_LEN;
    end else if (i_cmd.alloc > EXT_MAX_LEN) begin
      req_len = EXT_MAX_LEN;
    end else begin
      req_len = i_cmd.alloc;
    end
  end

  // Byte selection for the sense stream
  always_comb begin
    sel_byte = 8'h00;
    if (!sel_ext) begin
      case (sel_idx)
        8'h00: sel_byte = {held.addr_valid, held.error_class, held.error_code};
        // top bits zero, address high first
        8'h01: sel_byte = {3'h0, held.lba[20:16]};
        8'h02: sel_byte = held.lba[15:8];
        8'h03: sel_byte = held.lba[7:0];
        default: sel_byte = 8'h00;
      endcase
    end else begin
      case (sel_idx)
        // extended layout with address and key
        8'h00: sel_byte = {held.addr_valid, EXT_CLASS, EXT_FORMAT};
        8'h01: sel_byte = 8'h00;
        8'h02: sel_byte = {4'h0, held.sense_key};
        8'h03: sel_byte = held.lba[31:24];
        8'h04: sel_byte = held.lba[23:16];
        8'h05: sel_byte = held.lba[15:8];
        8'h06: sel_byte = held.lba[7:0];
        default: sel_byte = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    next_count = count;
    next_idx = idx;
    next_ext = ext;
    next_link = link;
    next_flag = flag;
    next_good = good;
    next_lun = lun;
    next_busy = busy;
    next_disc = disc;
    next_din_valid = din_valid;
    next_din_byte = din_byte;
    next_stat_valid = 1'b0;
    next_stat = stat;
    next_link_next = 1'b0;
    next_intr = 1'b0;
    next_abort_wr = wp_hit && i_write_active;
    sel_idx = idx;
    sel_ext = ext;
    case (state)
      S_IDLE: begin
        if (i_cmd_valid) begin
          next_busy = 1'b1;
          next_lun = i_cmd.lun_byte[LUN_MSB:LUN_LSB];
          next_link = i_cmd.ctrl[LINK_BIT];
          next_flag = i_cmd.ctrl[FLAG_BIT];
          next_good = cmd_ok;
          next_count = req_len;
          next_ext = i_cmd.alloc > STD_LEN;
          next_idx = 8'h00;
          if (!cmd_ok) begin
            next_state = S_STAT;
          end else if (i_lun_busy_other && i_disc_supported) begin
            next_disc = 1'b1;
            next_state = S_DISC;
          end else begin
            next_state = S_DATA;
            next_din_valid = 1'b1;
            sel_ext = i_cmd.alloc > STD_LEN;
            sel_idx = 8'h00;
            next_din_byte = sel_byte;
          end
        end
      end
      S_DISC: begin
        if (!i_lun_busy_other) begin
          next_disc = 1'b0;
          next_state = S_DATA;
          next_din_valid = 1'b1;
          sel_idx = 8'h00;
          next_din_byte = sel_byte;
        end
      end
      S_DATA: begin
        if (din_valid && i_din_ack) begin
          sel_idx = idx + 8'h01;
          next_idx = idx + 8'h01;
          if (idx + 8'h01 >= count) begin
            next_din_valid = 1'b0;
            next_state = S_STAT;
          end else begin
            next_din_byte = sel_byte;
          end
        end
      end
      S_STAT: begin
        // status every command; link follows only success
        next_stat_valid = 1'b1;
        next_busy = 1'b0;
        next_state = S_IDLE;
        if (!good) begin
          next_stat = ST_CHECK;
        end else if (link) begin
          next_stat = ST_LINKED_GOOD;
          next_link_next = 1'b1;
          next_intr = flag;
        end else begin
          next_stat = ST_GOOD;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      count <= 8'h00;
      idx <= 8'h00;
      ext <= 1'b0;
      link <= 1'b0;
      flag <= 1'b0;
      good <= 1'b0;
      lun <= 3'h0;
      busy <= 1'b0;
      disc <= 1'b0;
      din_valid <= 1'b0;
      din_byte <= 8'h00;
      stat_valid <= 1'b0;
      stat <= 8'h00;
      link_next <= 1'b0;
      intr <= 1'b0;
      abort_wr <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      idx <= next_idx;
      ext <= next_ext;
      link <= next_link;
      flag <= next_flag;
      good <= next_good;
      lun <= next_lun;
      busy <= next_busy;
      disc <= next_disc;
      din_valid <= next_din_valid;
      din_byte <= next_din_byte;
      stat_valid <= next_stat_valid;
      stat <= next_stat;
      link_next <= next_link_next;
      intr <= next_intr;
      abort_wr <= next_abort_wr;
    end
  end

  assign o_busy = busy;
  assign o_disconnect = disc;
  assign o_din_valid = din_valid;
  assign o_din_byte = din_byte;
  assign o_status_valid = stat_valid;
  assign o_status = stat;
  assign o_link_next = link_next;
  assign o_intr_req = intr;
  assign o_lun = lun;
  assign o_abort_write = abort_wr;

  sequence seq_data_done;
    din_valid && i_din_ack && (idx + 8'h01 >= count);
  endsequence

  sequence seq_status_out;
    ##2 stat_valid;
  endsequence

  a_data_then_status: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    seq_data_done |-> seq_status_out) else $error("status did not follow data");
  a_std_len_four: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == S_DATA && !ext) |-> count == STD_LEN) else $error("standard length not four");
  a_ext_len_cap: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == S_DATA && ext) |-> (count > STD_LEN && count <= EXT_MAX_LEN))
    else $error("extended length out of range");
  a_intr_needs_link: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    intr |-> (link_next && flag && link)) else $error("interrupt without link");
  a_link_on_good: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    link_next |-> (stat_valid && stat == ST_LINKED_GOOD)) else $error("link without good");
  a_disc_cond: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(disc) |-> $past(i_lun_busy_other) && $past(i_disc_supported))
    else $error("disconnect without cause");
  a_bad_op_check: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == S_IDLE && i_cmd_valid && i_cmd.opcode != OPC_SENSE)
    |-> ##2 (stat_valid && stat == ST_CHECK)) else $error("bad opcode not checked");
  a_std_b1_zero: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (din_valid && !ext && idx == 8'h01) |-> o_din_byte[7:5] == 3'h0)
    else $error("standard byte 1 high bits set");
  a_wp_abort: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (wp_hit && i_write_active) |=> abort_wr) else $error("write not aborted");
endmodule
`default_nettype wire

// >>> bench/initiator_model.sv
// Initiator model that takes sense bytes promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module initiator_model (
  input wire logic i_clk_sys,
  input wire logic i_clear,
  input wire logic i_slow,
  input wire logic i_din_valid,
  input wire logic [7:0] i_din_byte,
  output logic o_din_ack,
  output logic [3:0] o_count,
  output logic [7:0] o_bytes [8]
);
  initial begin
    o_din_ack = 1'b0;
    o_count = 4'h0;
  end
  always @(posedge i_clk_sys) begin
    if (i_clear) begin
      o_count <= 4'h0;
    end else if (i_din_valid && o_din_ack) begin
      if (o_count < 4'h8) begin
        o_bytes[o_count[2:0]] <= i_din_byte;
      end
      o_count <= o_count + 4'h1;
    end
  end
  // Stalls every other cycle when slow
  always @(negedge i_clk_sys) begin
    o_din_ack <= i_slow ? ~o_din_ack : 1'b1;
  end
endmodule
`default_nettype wire

// >>> bench/sense_reporter_tb.sv
// Self-checking bench for the sense request interpreter
`timescale 1ns/1ps
`default_nettype none
module sense_reporter_tb;
  import sense_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic cv = 0;
  cdb_t cmd = '0;
  logic bo = 0;
  logic ds = 0;
  logic acc = 0;
  logic ev = 0;
  sense_t err = '0;
  logic wa = 0;
  logic clr = 0;
  logic slow = 0;
  logic ack, busy, disc, dv, sv, lnk, irq, abw;
  logic [7:0] db, st;
  logic [2:0] lun;
  logic [3:0] cnt;
  logic [7:0] got [8];
  sense_t held = '0;
  int fails = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  sense_reporter i_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_cmd_valid(cv), .i_cmd(cmd),
    .i_lun_busy_other(bo), .i_disc_supported(ds), .i_access_cmd(acc), .i_err_valid(ev),
    .i_err(err), .i_write_active(wa), .i_din_ack(ack), .o_busy(busy), .o_disconnect(disc),
    .o_din_valid(dv), .o_din_byte(db), .o_status_valid(sv), .o_status(st),
    .o_link_next(lnk), .o_intr_req(irq), .o_lun(lun), .o_abort_write(abw));
  initiator_model i_host (.i_clk_sys(clk), .i_clear(clr), .i_slow(slow), .i_din_valid(dv),
    .i_din_byte(db), .o_din_ack(ack), .o_count(cnt), .o_bytes(got));

  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  function automatic cdb_t mk(input logic [7:0] al, input logic [7:0] ct, input logic [2:0] u);
    mk = '{ctrl: ct, alloc: al, rsv3: 8'h00, rsv2: 8'h00, lun_byte: {u, 5'h00}, opcode: OPC_SENSE};
  endfunction

  function automatic logic [7:0] exp_b(input sense_t s, input logic x, input int i);
    logic [7:0] e [8];
    if (x) begin
      e = '{{s.addr_valid, EXT_CLASS, EXT_FORMAT}, 8'h00, {4'h0, s.sense_key},
        s.lba[31:24], s.lba[23:16], s.lba[15:8], s.lba[7:0], 8'h00};
    end else begin
      e = '{{s.addr_valid, s.error_class, s.error_code}, {3'h0, s.lba[20:16]},
        s.lba[15:8], s.lba[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
    end
    return e[i];
  endfunction

  task automatic chk_read(input logic x, input int n);
    chk8({4'h0, cnt}, 8'(n));
    for (int i = 0; i < n; i++) begin
      chk8(got[i], exp_b(held, x, i));
    end
  endtask

  task automatic load(input sense_t s, input logic a);
    @(negedge clk);
    err = s;
    ev = 1;
    acc = a;
    @(negedge clk);
    ev = 0;
    acc = 0;
    held = s;
  endtask

  task automatic start(input cdb_t c);
    @(negedge clk);
    cmd = c;
    cv = 1;
    clr = 1;
    @(negedge clk);
    cv = 0;
    clr = 0;
  endtask

  task automatic wait_status(output logic [7:0] s, output logic l, output logic r);
    int n;
    n = 0;
    while (sv !== 1'b1) begin
      if (n == 300) begin
        fails++;
        tally_and_finish();
      end
      @(negedge clk);
      n++;
    end
    s = st;
    l = lnk;
    r = irq;
  endtask

  task automatic run(input cdb_t c, output logic [7:0] s, output logic l, output logic r);
    start(c);
    wait_status(s, l, r);
  endtask

  task automatic sc_codes;
    logic [7:0] s;
    logic l, r;
    sense_t e;
    for (int i = 0; i < 17; i++) begin
      e = '{i[0], (i < 9) ? CLS_DRIVE : CLS_TARGET,
        (i < 9) ? ((i == 8) ? CD_NO_MEDIA : i[3:0]) : 4'(i - 9), 4'h0, {i[7:0], 24'hF5A5C3}};
      load(e, 1'b0);
      run(mk(8'h04, 8'h00, 3'h0), s, l, r);
      chk_read(1'b0, 4);
    end
  endtask

  task automatic sc_format;
    logic [7:0] al [7];
    logic [7:0] s;
    logic l, r;
    int n;
    al = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'hFF};
    load('{1'b1, CLS_TARGET, CD_SEEK, 4'hB, 32'h3CF5A5C3}, 1'b0);
    for (int i = 0; i < 7; i++) begin
      slow = i[0];
      n = (al[i] <= STD_LEN) ? 4 : ((al[i] > EXT_MAX_LEN) ? int'(EXT_MAX_LEN) : int'(al[i]));
      run(mk(al[i], 8'h00, 3'h5), s, l, r);
      chk8(s, ST_GOOD);
      chk8({5'h00, lun}, 8'h05);
      chk_read(al[i] > STD_LEN, n);
    end
    slow = 0;
  endtask

  task automatic sc_link;
    logic [7:0] s;
    logic l, r;
    for (int c = 0; c < 4; c++) begin
      run(mk(8'h04, 8'(c), 3'h1), s, l, r);
      chk8(s, c[0] ? ST_LINKED_GOOD : ST_GOOD);
      chk1(l, c[0]);
      chk1(r, c == 3);
    end
  endtask

  task automatic sc_refuse;
    cdb_t b [4];
    logic [7:0] s;
    logic l, r;
    for (int i = 0; i < 4; i++) begin
      b[i] = mk(8'h04, 8'h00, 3'h3);
    end
    b[0].rsv2 = 8'h01;
    b[1].rsv3 = 8'h80;
    b[2].lun_byte[0] = 1'b1;
    b[3].opcode = 8'h08;
    for (int i = 0; i < 4; i++) begin
      run(b[i], s, l, r);
      chk8(s, ST_CHECK);
      chk8({4'h0, cnt}, 8'h00);
    end
  endtask

  task automatic sc_disconnect;
    logic [7:0] s;
    logic l, r;
    bo = 1;
    ds = 1;
    start(mk(8'h04, 8'h00, 3'h2));
    repeat (3) @(negedge clk);
    chk1(disc, 1'b1);
    chk1(busy, 1'b1);
    chk8({4'h0, cnt}, 8'h00);
    cmd = mk(8'h08, 8'h01, 3'h2);
    cv = 1;
    @(negedge clk);
    cv = 0;
    bo = 0;
    wait_status(s, l, r);
    chk8(s, ST_GOOD);
    chk1(busy, 1'b0);
    chk_read(1'b0, 4);
    ds = 0;
    bo = 1;
    start(mk(8'h04, 8'h00, 3'h2));
    chk1(disc, 1'b0);
    wait_status(s, l, r);
    chk_read(1'b0, 4);
    bo = 0;
  endtask

  task automatic sc_clear;
    logic [7:0] s;
    logic l, r;
    load('{1'b1, CLS_TARGET, CD_DMA_TIMEOUT, 4'h6, 32'h12F5A5C3}, 1'b0);
    repeat (2) begin
      run(mk(8'h04, 8'h00, 3'h0), s, l, r);
      chk_read(1'b0, 4);
    end
    @(negedge clk);
    acc = 1;
    @(negedge clk);
    acc = 0;
    held = '0;
    run(mk(8'h04, 8'h00, 3'h0), s, l, r);
    chk_read(1'b0, 4);
    load('{1'b0, CLS_TARGET, CD_ID_MARK, 4'h3, 32'hA5123456}, 1'b1);
    run(mk(8'h08, 8'h00, 3'h0), s, l, r);
    chk_read(1'b1, 8);
  endtask

  task automatic sc_write_prot;
    logic seen;
    for (int w = 0; w < 2; w++) begin
      wa = w[0];
      seen = 0;
      @(negedge clk);
      err = '{1'b0, CLS_TARGET, CD_WRITE_PROT, 4'h7, 32'h0};
      ev = 1;
      repeat (4) begin
        @(negedge clk);
        ev = 0;
        seen |= abw;
      end
      chk1(seen, w[0]);
    end
    wa = 0;
  endtask

  initial begin
    repeat (3) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
    sc_codes();
    sc_format();
    sc_link();
    sc_refuse();
    sc_disconnect();
    sc_clear();
    sc_write_prot();
    tally_and_finish();
  end
endmodule
`default_nettype wire
